// ### rtl/fbp_pkg.sv
// Operation
// R1: Boot pin sampled at reset release; high selects flash boot, low boot ROM.
// R2: Single boot mode maps boot ROM at zero and flash at the mirror base.
// R3: Single chip mode decodes flash at zero and at the mirror window.
// R4: Block 0 is protected per page, blocks 1 upward per block.
// R5: Protect program sets the addressed bit; protect erase clears it.
// R6: Secured only when security flag is one and all protect bits are one.
// R7: While secured, CPU reads flash; debug and trace are disabled.
// R8: While secured, commands are rejected; protect erase runs a full chip erase.
// R9: Cold reset forces the security flag to one.
// R10: Flag change needs key write then value write within 16 clocks, 32-bit.
// R11: Flag at zero masks protect bits to zero without changing stored values.
// R12: Flag one with some bits set blocks protected writes; tools stay connected.
// R13: Swap exchanges region at zero with the following equal-size region; at 512K the code remaps only region zero, upper region unchanged.
// R14: Swap size changes only through the memory swap command, setting bits.
// R15: Swap command bit 0 activates swap; bit 1 releases it.
// R16: Current swap condition is readable from the swap state field.
// R17: Software releases security before a swap, else commands erase flash.
// R18: Software erases protect bits before swap; protected regions refuse commands.
// R19: Software checks the following region is blank, then copies region zero.
// R20: Dedicated sequencer performs program and erase with polling status.
// R21: Erase suspend and resume are not supported.
// R22: Protection is by software protect bits only, no hardware pin.
// R23: Every protect bit is readable in the protect status registers.
// R24: Swap state 00 or 11 not swapped, 01 swapping, 10 prohibited.
// R25: Swap size 000 4K, 001 8K, 010 16K, 011 32K, 100 512K.
// R26: Value write outside the window is ignored; flag stays unchanged.
package fbp_pkg;
    localparam logic [31:0] SEC_KEY = 32'hA74A9D23;
    localparam int KEY_WINDOW_CLKS = 16;
    localparam logic [31:0] MIRROR_BASE = 32'h5E00_0000;
    localparam logic [31:0] MIRROR_LAST = 32'h5E0F_FFFF;
    localparam logic [31:0] FLASH_LAST = 32'h000F_FFFF;
    localparam logic [31:0] BOOTROM_LAST = 32'h0000_0FFF;
    localparam int NUM_PAGES0 = 8;
    localparam int NUM_BLOCKS = 32;
    localparam int PROT_BITS = 39;
    localparam int BLOCK_SHIFT = 15;
    localparam int PAGE_SHIFT = 12;
    localparam int ERASE_CLKS = 8;
    localparam logic [1:0] SWP_NONE = 2'h0;
    localparam logic [1:0] SWP_ACTIVE = 2'h1;
    localparam logic [1:0] SWP_BAD = 2'h2;
    localparam logic [2:0] SZ_4K = 3'h0;
    localparam logic [2:0] SZ_8K = 3'h1;
    localparam logic [2:0] SZ_16K = 3'h2;
    localparam logic [2:0] SZ_32K = 3'h3;
    localparam logic [2:0] SZ_512K = 3'h4;
    typedef enum logic [2:0] {
        CMD_NONE = 3'h0,
        CMD_PROT_PROG = 3'h1,
        CMD_PROT_ERASE = 3'h2,
        CMD_SWAP = 3'h3,
        CMD_PROGRAM = 3'h4,
        CMD_ERASE = 3'h5
    } fbp_cmd_t;
    typedef enum logic [1:0] {
        ST_READY = 2'h0,
        ST_BUSY = 2'h1,
        ST_CHIP_ERASE = 2'h2
    } fbp_state_t;
endpackage : fbp_pkg

// ### rtl/fbp_key_unlock.sv
`timescale 1ns/10ps
`default_nettype none
module fbp_key_unlock (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic cold_reset_in,
    input wire logic key_wr_in,
    input wire logic key_wr_word_in,
    input wire logic [31:0] key_wdata_in,
    output logic sec_flag_out,
    output logic window_open_out
);
    logic [4:0] window_count;
    logic armed;
    logic word_ok;
    assign word_ok = key_wr_in && key_wr_word_in;
    assign window_open_out = armed;
    // ----------------------------------------
    // Key window
    // ----------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            armed <= 1'b0;
            window_count <= 5'h00;
        end else if (word_ok && !armed && key_wdata_in == fbp_pkg::SEC_KEY) begin
            armed <= 1'b1; // R10
            window_count <= 5'h00;
        end else if (armed) begin
            if (word_ok || window_count == 5'(fbp_pkg::KEY_WINDOW_CLKS - 1)) begin
                armed <= 1'b0; // R26
            end
            window_count <= window_count + 5'h01;
        end
    end
    // ----------------------------------------
    // Security flag
    // ----------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (cold_reset_in) begin
            sec_flag_out <= 1'b1; // R9
        end else if (armed && word_ok) begin
            sec_flag_out <= key_wdata_in[0]; // R10
        end
    end
    property p_late_value_ignored;
        @(posedge sys_clk_in) disable iff (reset_in || cold_reset_in)
        (word_ok && !armed) |=> sec_flag_out == $past(sec_flag_out);
    endproperty
    a_late_value_ignored: assert property (p_late_value_ignored) // R26
        else $error("Flag changed without armed key");
    property p_window_closes;
        @(posedge sys_clk_in) disable iff (reset_in)
        $rose(armed) |-> ##[1:16] !armed;
    endproperty
    a_window_closes: assert property (p_window_closes) // R10
        else $error("Key window stayed open too long");
endmodule : fbp_key_unlock
`default_nettype wire

// ### rtl/fbp_addr_map.sv
`timescale 1ns/10ps
`default_nettype none
module fbp_addr_map (
    input wire logic boot_rom_mode_in,
    input wire logic swap_on_in,
    input wire logic [2:0] swap_size_in,
    input wire logic [31:0] addr_in,
    output logic flash_sel_out,
    output logic rom_sel_out,
    output logic [19:0] flash_off_out
);
    function automatic logic [19:0] region_bytes(input logic [2:0] sz);
        case (sz)
            fbp_pkg::SZ_4K: region_bytes = 20'h01000;
            fbp_pkg::SZ_8K: region_bytes = 20'h02000;
            fbp_pkg::SZ_16K: region_bytes = 20'h04000;
            fbp_pkg::SZ_32K: region_bytes = 20'h08000;
            fbp_pkg::SZ_512K: region_bytes = 20'h80000; // R25
            default: region_bytes = 20'h00000;
        endcase
    endfunction : region_bytes
    logic [19:0] raw_off;
    logic [19:0] rsz;
    logic in_low;
    logic in_mirror;
    always_comb begin
        rsz = region_bytes(swap_size_in);
        in_mirror = addr_in >= fbp_pkg::MIRROR_BASE && addr_in <= fbp_pkg::MIRROR_LAST;
        in_low = addr_in <= fbp_pkg::FLASH_LAST;
        raw_off = addr_in[19:0];
        if (boot_rom_mode_in) begin
            rom_sel_out = addr_in <= fbp_pkg::BOOTROM_LAST; // R2
            flash_sel_out = in_mirror; // R2
        end else begin
            rom_sel_out = 1'b0;
            flash_sel_out = in_low || in_mirror; // R3
        end
        flash_off_out = raw_off;
        // Size code outside the table leaves the map unswapped
        if (swap_on_in && rsz != 20'h00000) begin
            if (raw_off < rsz) begin
                flash_off_out = raw_off + rsz; // R13
            end else if (raw_off < 20'(rsz << 1)) begin
                flash_off_out = raw_off - rsz; // R13
            end
        end
    end
endmodule : fbp_addr_map
`default_nettype wire

// ### rtl/fbp_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module fbp_ctrl #(
    parameter int ERASE_CYCLES = fbp_pkg::ERASE_CLKS
) (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic cold_reset_in,
    input wire logic startup_source_pin_in,
    input wire logic [31:0] cpu_addr_in,
    input wire logic cpu_read_in,
    input wire logic key_wr_in,
    input wire logic key_wr_word_in,
    input wire logic [31:0] key_wdata_in,
    input wire logic cmd_valid_in,
    input wire logic [2:0] cmd_code_in,
    input wire logic [19:0] cmd_addr_in,
    input wire logic [7:0] cmd_data_in,
    input wire logic seq_done_in,
    output logic cmd_ready_out,
    output logic flash_sel_out,
    output logic rom_sel_out,
    output logic [19:0] flash_off_out,
    output logic flash_read_ok_out,
    output logic boot_rom_mode_out,
    output logic security_enable_flag_out,
    output logic secured_out,
    output logic debug_enable_out,
    output logic cmd_rejected_out,
    output logic seq_start_out,
    output logic [2:0] seq_cmd_out,
    output logic [19:0] seq_addr_out,
    output logic busy_out,
    output logic chip_erase_out,
    output logic [31:0] protect_status_0_out,
    output logic [31:0] protect_status_1_out,
    output logic [31:0] swap_status_register_out
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    fbp_pkg::fbp_state_t state;
    logic [fbp_pkg::PROT_BITS-1:0] prot;
    logic [1:0] swap_state_field;
    logic [2:0] swap_size;
    logic [5:0] swap_flags;
    logic boot_sampled;
    logic [7:0] erase_count;
    logic all_prot;
    logic [fbp_pkg::PROT_BITS-1:0] prot_eff;
    logic target_prot;
    logic sec_flag;
    logic cmd_take;
    logic swap_on;
    fbp_pkg::fbp_cmd_t cmd;

    // Bit index of the protect bit covering an offset: pages of block 0 first
    function automatic logic [5:0] prot_index(input logic [19:0] off);
        if (off[19:fbp_pkg::BLOCK_SHIFT] == 5'h00) begin
            prot_index = {3'h0, off[fbp_pkg::PAGE_SHIFT+2:fbp_pkg::PAGE_SHIFT]}; // R4
        end else begin
            prot_index = 6'(off[19:fbp_pkg::BLOCK_SHIFT]) + 6'h07; // R4
        end
    endfunction : prot_index

    fbp_key_unlock u_key (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .cold_reset_in(cold_reset_in),
        .key_wr_in(key_wr_in),
        .key_wr_word_in(key_wr_word_in),
        .key_wdata_in(key_wdata_in),
        .sec_flag_out(sec_flag),
        .window_open_out()
    );

    fbp_addr_map u_map (
        .boot_rom_mode_in(boot_rom_mode_out),
        .swap_on_in(swap_on),
        .swap_size_in(swap_size),
        .addr_in(cpu_addr_in),
        .flash_sel_out(flash_sel_out),
        .rom_sel_out(rom_sel_out),
        .flash_off_out(flash_off_out)
    );

    assign cmd = fbp_pkg::fbp_cmd_t'(cmd_code_in);
    assign swap_on = swap_state_field == fbp_pkg::SWP_ACTIVE; // R24
    assign all_prot = &prot;
    assign security_enable_flag_out = sec_flag;
    assign secured_out = sec_flag && all_prot; // R6
    assign debug_enable_out = !secured_out; // R7
    assign flash_read_ok_out = cpu_read_in && flash_sel_out; // R7
    // Masked copy only feeds write gating; stored bits stay intact
    assign prot_eff = sec_flag ? prot : '0; // R11
    assign target_prot = prot_eff[prot_index(cmd_addr_in)]; // R12
    assign busy_out = state != fbp_pkg::ST_READY;
    assign chip_erase_out = state == fbp_pkg::ST_CHIP_ERASE;
    // Ready stays high while secured so a refused command is consumed
    assign cmd_ready_out = state == fbp_pkg::ST_READY;
    assign cmd_take = cmd_valid_in && cmd_ready_out;

    // ----------------------------------------
    // Boot mode capture
    // ----------------------------------------
    always_ff @(posedge sys_clk_in) begin
        boot_sampled <= reset_in;
        if (reset_in) begin
            boot_rom_mode_out <= 1'b0;
        end else if (boot_sampled) begin
            boot_rom_mode_out <= !startup_source_pin_in; // R1
        end
    end

    // ----------------------------------------
    // Command sequencer
    // ----------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            state <= fbp_pkg::ST_READY;
            seq_start_out <= 1'b0;
            seq_cmd_out <= 3'h0;
            seq_addr_out <= 20'h00000;
            cmd_rejected_out <= 1'b0;
            erase_count <= 8'h00;
        end else begin
            seq_start_out <= 1'b0;
            cmd_rejected_out <= 1'b0;
            case (state)
                fbp_pkg::ST_READY: begin
                    if (cmd_take) begin
                        seq_cmd_out <= cmd_code_in;
                        seq_addr_out <= cmd_addr_in;
                        if (secured_out && cmd == fbp_pkg::CMD_PROT_ERASE) begin
                            state <= fbp_pkg::ST_CHIP_ERASE; // R8
                            erase_count <= 8'h00;
                        end else if (secured_out) begin
                            cmd_rejected_out <= 1'b1; // R8
                        end else if ((cmd == fbp_pkg::CMD_PROGRAM ||
                                      cmd == fbp_pkg::CMD_ERASE) && target_prot) begin
                            cmd_rejected_out <= 1'b1; // R12
                        end else if (cmd == fbp_pkg::CMD_PROGRAM ||
                                     cmd == fbp_pkg::CMD_ERASE) begin
                            seq_start_out <= 1'b1; // R20
                            state <= fbp_pkg::ST_BUSY;
                        end
                    end
                end
                fbp_pkg::ST_BUSY: begin
                    // No suspend path: only completion leaves busy
                    if (seq_done_in) begin
                        state <= fbp_pkg::ST_READY; // R21
                    end
                end
                fbp_pkg::ST_CHIP_ERASE: begin
                    erase_count <= erase_count + 8'h01;
                    if (erase_count == 8'(ERASE_CYCLES - 1)) begin
                        state <= fbp_pkg::ST_READY;
                    end
                end
                default: begin
                    state <= fbp_pkg::ST_READY;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Protect bits
    // ----------------------------------------
    // Protect bits live in flash, so only a cold reset or a chip erase wipes them
    always_ff @(posedge sys_clk_in) begin
        if (cold_reset_in) begin
            prot <= '0;
        end else if (chip_erase_out) begin
            prot <= '0; // R8
        end else if (cmd_take && !secured_out) begin // R22
            if (cmd == fbp_pkg::CMD_PROT_PROG) begin
                prot[prot_index(cmd_addr_in)] <= 1'b1; // R5
            end else if (cmd == fbp_pkg::CMD_PROT_ERASE) begin
                prot[prot_index(cmd_addr_in)] <= 1'b0; // R5
            end
        end
    end

    // ----------------------------------------
    // Swap status
    // ----------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (cold_reset_in || chip_erase_out) begin
            swap_state_field <= fbp_pkg::SWP_NONE; // R24
            swap_size <= fbp_pkg::SZ_4K;
            swap_flags <= 6'h00;
        end else if (cmd_take && !secured_out && cmd == fbp_pkg::CMD_SWAP) begin
            // Swap command only sets bits, never clears them
            swap_state_field <= swap_state_field | cmd_data_in[1:0]; // R15
            swap_size <= swap_size | cmd_data_in[4:2]; // R14
            swap_flags <= swap_flags | {4'h0, cmd_data_in[6:5]};
        end
    end

    // ----------------------------------------
    // Status views
    // ----------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            protect_status_0_out <= 32'h0000_0000;
            protect_status_1_out <= 32'h0000_0001;
            swap_status_register_out <= 32'h0000_0000;
        end else begin
            protect_status_0_out <= {prot[22:8], 1'b0, prot[7:0], 7'h00, !busy_out}; // R23
            protect_status_1_out <= {prot[38:23], 15'h0000, 1'b1}; // R23
            swap_status_register_out <= {21'h000000, swap_size,
                                         swap_flags, swap_state_field}; // R16
        end
    end

    property p_secure_needs_all;
        @(posedge sys_clk_in) disable iff (reset_in)
        secured_out |-> (sec_flag && prot == '1 && !debug_enable_out);
    endproperty
    a_secure_needs_all: assert property (p_secure_needs_all) // R6
        else $error("Secured without flag and all protect bits");
    property p_secured_reject;
        @(posedge sys_clk_in) disable iff (reset_in)
        (cmd_take && secured_out && cmd == fbp_pkg::CMD_PROGRAM) |=>
            (cmd_rejected_out && !seq_start_out);
    endproperty
    a_secured_reject: assert property (p_secured_reject) // R8
        else $error("Secured command not rejected");
    property p_secured_chip_erase;
        @(posedge sys_clk_in) disable iff (reset_in || cold_reset_in)
        (cmd_take && secured_out && cmd == fbp_pkg::CMD_PROT_ERASE) |=>
            chip_erase_out ##[1:300] prot == '0;
    endproperty
    a_secured_chip_erase: assert property (p_secured_chip_erase) // R8
        else $error("Protect erase while secured did not chip erase");
    property p_mask_when_off;
        @(posedge sys_clk_in) disable iff (reset_in)
        (!sec_flag && cmd_take && cmd == fbp_pkg::CMD_PROGRAM) |=>
            (seq_start_out && !cmd_rejected_out);
    endproperty
    a_mask_when_off: assert property (p_mask_when_off) // R11
        else $error("Program refused with security flag clear");
    property p_prot_prog;
        @(posedge sys_clk_in) disable iff (reset_in || cold_reset_in)
        (cmd_take && !secured_out && !chip_erase_out && cmd == fbp_pkg::CMD_PROT_PROG)
            |=> prot[prot_index($past(cmd_addr_in))];
    endproperty
    a_prot_prog: assert property (p_prot_prog) // R5
        else $error("Protect program did not set bit");
    property p_boot_mode;
        @(posedge sys_clk_in) disable iff (reset_in)
        $fell(boot_sampled) |=> boot_rom_mode_out == !$past(startup_source_pin_in, 2);
    endproperty
    a_boot_mode: assert property (p_boot_mode) // R1
        else $error("Boot mode not taken from pin");
endmodule : fbp_ctrl
`default_nettype wire

// ### dv/fbp_seq_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Far-side program/erase sequencer
// ----------------------------------------
module fbp_seq_model (
    input wire logic sys_clk_in,
    input wire logic seq_start_in,
    input wire logic [3:0] done_delay_in,
    output logic seq_done_out
);
    // Delay is driven by the testbench, so one run sees both a prompt and a slow sequencer
    initial begin
        seq_done_out = 1'b0;
        forever begin
            @(posedge sys_clk_in);
            #1;
            if (seq_start_in === 1'b1) begin
                repeat (done_delay_in) @(posedge sys_clk_in);
                #1 seq_done_out = 1'b1;
                @(posedge sys_clk_in);
                #1 seq_done_out = 1'b0;
            end
        end
    end
endmodule : fbp_seq_model
`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic sys_clk_in = 1'b0, reset_in = 1'b1, cold_reset_in = 1'b1, pin = 1'b1;
    logic [31:0] cpu_addr_in = 32'h0, key_wdata_in = 32'h0;
    logic cpu_read_in = 1'b0, key_wr_in = 1'b0, key_wr_word_in = 1'b0, cmd_valid_in = 1'b0;
    logic [2:0] cmd_code_in = 3'h0;
    logic [19:0] cmd_addr_in = 20'h0;
    logic [7:0] cmd_data_in = 8'h0;
    logic [3:0] done_delay = 4'h0;
    logic seq_done_in, cmd_ready_out, flash_sel_out, rom_sel_out, flash_read_ok_out;
    logic boot_rom_mode_out, security_enable_flag_out, secured_out, debug_enable_out;
    logic cmd_rejected_out, seq_start_out, busy_out, chip_erase_out;
    logic [2:0] seq_cmd_out;
    logic [19:0] flash_off_out, seq_addr_out;
    logic [31:0] psr0, psr1, swpsr;
    int failures = 0, total_checks = 0, cycles = 0;

    fbp_ctrl #(.ERASE_CYCLES(8)) u_dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
        .cold_reset_in(cold_reset_in), .startup_source_pin_in(pin), .cpu_addr_in(cpu_addr_in),
        .cpu_read_in(cpu_read_in), .key_wr_in(key_wr_in), .key_wr_word_in(key_wr_word_in),
        .key_wdata_in(key_wdata_in), .cmd_valid_in(cmd_valid_in), .cmd_code_in(cmd_code_in),
        .cmd_addr_in(cmd_addr_in), .cmd_data_in(cmd_data_in), .seq_done_in(seq_done_in),
        .cmd_ready_out(cmd_ready_out), .flash_sel_out(flash_sel_out),
        .rom_sel_out(rom_sel_out), .flash_off_out(flash_off_out),
        .flash_read_ok_out(flash_read_ok_out), .boot_rom_mode_out(boot_rom_mode_out),
        .security_enable_flag_out(security_enable_flag_out), .secured_out(secured_out),
        .debug_enable_out(debug_enable_out), .cmd_rejected_out(cmd_rejected_out),
        .seq_start_out(seq_start_out), .seq_cmd_out(seq_cmd_out),
        .seq_addr_out(seq_addr_out), .busy_out(busy_out), .chip_erase_out(chip_erase_out),
        .protect_status_0_out(psr0), .protect_status_1_out(psr1),
        .swap_status_register_out(swpsr));
    fbp_seq_model u_seq (.sys_clk_in(sys_clk_in), .seq_start_in(seq_start_out),
        .done_delay_in(done_delay), .seq_done_out(seq_done_in));

    initial forever #10 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            finish_test();
        end
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task tick();
        @(posedge sys_clk_in);
        #1;
    endtask : tick
    task chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task finish_test();
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test
    task reset_dut(input logic boot_pin, input logic cold);
        reset_in = 1'b1;
        cold_reset_in = cold;
        pin = boot_pin;
        repeat (3) tick();
        reset_in = 1'b0;
        cold_reset_in = 1'b0;
        repeat (3) tick();
    endtask : reset_dut
    task wait_ready();
        int n;
        n = 0;
        while (cmd_ready_out !== 1'b1 && n < 100) begin
            tick();
            n++;
        end
        chk(cmd_ready_out, 1'b1);
    endtask : wait_ready
    // Answer code: bit 1 is a sequencer start, bit 0 a rejection pulse
    task do_cmd(input logic [2:0] code, input logic [19:0] addr, input logic [7:0] data,
                input logic [1:0] exp);
        wait_ready();
        cmd_valid_in = 1'b1;
        cmd_code_in = code;
        cmd_addr_in = addr;
        cmd_data_in = data;
        tick();
        cmd_valid_in = 1'b0;
        cmd_code_in = 3'h0;
        chk({seq_start_out, cmd_rejected_out}, exp);
        if (exp[1]) begin
            chk({busy_out, seq_cmd_out, seq_addr_out}, {1'b1, code, addr});
            wait_ready();
        end
        repeat (2) tick();
    endtask : do_cmd
    task key_seq(input int gap, input logic [31:0] val, input logic word);
        key_wr_in = 1'b1;
        key_wr_word_in = 1'b1;
        key_wdata_in = fbp_pkg::SEC_KEY;
        tick();
        // A back-to-back value write keeps the strobe up instead of toggling it
        if (gap > 1) begin
            key_wr_in = 1'b0;
            repeat (gap - 1) tick();
        end
        key_wr_in = 1'b1;
        key_wr_word_in = word;
        key_wdata_in = val;
        tick();
        key_wr_in = 1'b0;
        key_wr_word_in = 1'b0;
        repeat (20) tick();
    endtask : key_seq
    task chk_map(input logic [31:0] addr, input logic [1:0] sel, input logic [19:0] off);
        cpu_addr_in = addr;
        cpu_read_in = 1'b1;
        tick();
        chk({flash_sel_out, rom_sel_out}, sel);
        if (sel[1])
            chk(flash_off_out, off);
    endtask : chk_map
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_boot();
        reset_dut(1'b1, 1'b1);
        chk({boot_rom_mode_out, security_enable_flag_out}, 2'h1);
        chk({psr1, swpsr}, {32'h0000_0001, 32'h0});
        chk_map(32'h0000_0FFF, 2'h2, 20'h00FFF);
        chk_map(32'h000F_FFFF, 2'h2, 20'hFFFFF);
        chk_map(32'h5E0F_FFFF, 2'h2, 20'hFFFFF);
        chk_map(32'h5E10_0000, 2'h0, 20'h0);
        reset_dut(1'b0, 1'b0);
        chk(boot_rom_mode_out, 1'b1);
        chk_map(32'h0000_0FFF, 2'h1, 20'h0);
        chk_map(32'h5E00_0010, 2'h2, 20'h00010);
    endtask : t_boot
    task t_protect_key();
        reset_dut(1'b1, 1'b1);
        done_delay = 4'h5;
        do_cmd(fbp_pkg::CMD_PROT_PROG, 20'h00000, 8'h0, 2'h0);
        do_cmd(fbp_pkg::CMD_PROGRAM, 20'h00010, 8'h0, 2'h1);
        do_cmd(fbp_pkg::CMD_PROGRAM, 20'h01000, 8'h0, 2'h2);
        do_cmd(fbp_pkg::CMD_PROT_PROG, 20'h08000, 8'h0, 2'h0);
        do_cmd(fbp_pkg::CMD_ERASE, 20'h0C000, 8'h0, 2'h1);
        chk({psr0, 1'b0, debug_enable_out}, {32'h0002_0101, 2'h1});
        key_seq(17, 32'h0, 1'b1);
        chk(security_enable_flag_out, 1'b1);
        key_seq(2, 32'h0, 1'b0);
        chk(security_enable_flag_out, 1'b1);
        key_seq(16, 32'h0, 1'b1);
        chk(security_enable_flag_out, 1'b0);
        done_delay = 4'h0;
        do_cmd(fbp_pkg::CMD_PROGRAM, 20'h00010, 8'h0, 2'h2);
        chk(psr0, 32'h0002_0101);
        key_seq(1, 32'h1, 1'b1);
        chk(security_enable_flag_out, 1'b1);
        do_cmd(fbp_pkg::CMD_PROT_ERASE, 20'h00000, 8'h0, 2'h0);
        chk(psr0, 32'h0002_0001);
    endtask : t_protect_key
    task t_swap();
        reset_dut(1'b1, 1'b1);
        chk(secured_out, 1'b0);
        do_cmd(fbp_pkg::CMD_PROT_ERASE, 20'h0, 8'h0, 2'h0);
        do_cmd(fbp_pkg::CMD_ERASE, 20'h02000, 8'h0, 2'h2);
        do_cmd(fbp_pkg::CMD_PROGRAM, 20'h02000, 8'h0, 2'h2);
        do_cmd(fbp_pkg::CMD_SWAP, 20'h0, 8'h05, 2'h0);
        chk(swpsr, 32'h0000_0101);
        chk_map(32'h0000_0010, 2'h2, 20'h02010);
        chk_map(32'h0000_2010, 2'h2, 20'h00010);
        chk_map(32'h0000_4010, 2'h2, 20'h04010);
        do_cmd(fbp_pkg::CMD_SWAP, 20'h0, 8'h02, 2'h0);
        chk(swpsr, 32'h0000_0103);
        chk_map(32'h0000_0010, 2'h2, 20'h00010);
    endtask : t_swap
    task t_secure();
        int i;
        reset_dut(1'b1, 1'b1);
        for (i = 0; i < 8; i++)
            do_cmd(fbp_pkg::CMD_PROT_PROG, 20'(i * 32'h1000), 8'h0, 2'h0);
        for (i = 1; i < 32; i++)
            do_cmd(fbp_pkg::CMD_PROT_PROG, 20'(i * 32'h8000), 8'h0, 2'h0);
        chk({psr0, psr1}, {32'hFFFE_FF01, 32'hFFFF_0001});
        chk_map(32'h0000_0100, 2'h2, 20'h00100);
        chk({secured_out, debug_enable_out, flash_read_ok_out}, 3'h5);
        do_cmd(fbp_pkg::CMD_PROGRAM, 20'h40000, 8'h0, 2'h1);
        do_cmd(fbp_pkg::CMD_PROT_ERASE, 20'h0, 8'h0, 2'h0);
        chk(chip_erase_out, 1'b1);
        repeat (5) tick();
        chk(chip_erase_out, 1'b1);
        tick();
        chk(chip_erase_out, 1'b0);
        wait_ready();
        repeat (2) tick();
        chk({psr0, psr1}, {32'h0000_0001, 32'h0000_0001});
        chk({secured_out, debug_enable_out}, 2'h1);
    endtask : t_secure

    initial begin
        t_boot();
        t_protect_key();
        t_swap();
        t_secure();
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
